/* File: hdl/port_cfg_if.sv */
// Carrier of the two configuration registers between bank and decision logic
`timescale 1ns/1ps
interface port_cfg_if;
   logic [15:0] ctrlReg;
   logic [15:0] tagReg;
   modport src (output ctrlReg, output tagReg);
   modport dst (input ctrlReg, input tagReg);
endinterface

/* File: hdl/port_ingress_decide.sv */
// Per-packet ingress forwarding decision from the port configuration
`timescale 1ns/1ps
module port_ingress_decide (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Configuration
   port_cfg_if.dst cfg,
   // Packet descriptor
   input wire logic pktValid,
   input wire logic pktTagged,
   input wire logic [11:0] pktVid,
   input wire logic [2:0] pktPrio,
   input wire logic pktCfi,
   input wire logic [2:0] tableMembers,
   input wire logic [2:0] destMask,
   // Decision
   output logic decValid,
   output logic decDrop,
   output logic [11:0] lookupVid,
   output logic [2:0] outPrio,
   output logic [2:0] fwdMask,
   output logic rxMonitor,
   output logic learnOk,
   output logic [15:0] egressTag
);
   logic valid_r, valid_nxt, drop_r, drop_nxt, mon_r, mon_nxt, learn_r, learn_nxt;
   logic [11:0] vid_r, vid_nxt;
   logic [2:0] prio_r, prio_nxt, mask_r, mask_nxt;
   logic [15:0] tag_r, tag_nxt;

   // Config sampled only in the decision cycle, so later writes cannot touch it
   always_comb begin
      logic [15:0] c;
      logic [2:0] dPrio, inPrio;
      logic [11:0] dVid;
      logic untag;
      c = cfg.ctrlReg;
      dPrio = cfg.tagReg[port_vlan_pkg::PRIO_HI:port_vlan_pkg::PRIO_LO];
      dVid = cfg.tagReg[port_vlan_pkg::VID_HI:0];
      inPrio = pktTagged ? pktPrio : dPrio;
      untag = !pktTagged || pktVid == port_vlan_pkg::NULL_VID;
      valid_nxt = pktValid;
      vid_nxt = untag ? dVid : pktVid;
      drop_nxt = !c[port_vlan_pkg::RX_EN_BIT]
         || (c[port_vlan_pkg::FILT_BIT] && !tableMembers[port_vlan_pkg::SELF_BIT])
         || (c[port_vlan_pkg::DEF_VID_ONLY_BIT] && vid_nxt != dVid);
      prio_nxt = (c[port_vlan_pkg::PRIO_CEIL_BIT] && inPrio > dPrio) ? dPrio : inPrio;
      mask_nxt = destMask & c[port_vlan_pkg::MEMBER_HI:0];
      mon_nxt = c[port_vlan_pkg::RX_SNIFF_BIT];
      learn_nxt = !c[port_vlan_pkg::LEARN_OFF_BIT];
      // Untagged packets carry the port default tag out
      tag_nxt = pktTagged ? {pktPrio, pktCfi, vid_nxt} : cfg.tagReg;
      if (!pktValid) begin
         vid_nxt = vid_r;
         drop_nxt = drop_r;
         prio_nxt = prio_r;
         mask_nxt = mask_r;
         mon_nxt = mon_r;
         learn_nxt = learn_r;
         tag_nxt = tag_r;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         valid_r <= 1'b0;
         drop_r <= 1'b0;
         vid_r <= 12'h000;
         prio_r <= 3'h0;
         mask_r <= 3'h0;
         mon_r <= 1'b0;
         learn_r <= 1'b0;
         tag_r <= 16'h0000;
      end else begin
         valid_r <= valid_nxt;
         drop_r <= drop_nxt;
         vid_r <= vid_nxt;
         prio_r <= prio_nxt;
         mask_r <= mask_nxt;
         mon_r <= mon_nxt;
         learn_r <= learn_nxt;
         tag_r <= tag_nxt;
      end
   end

   assign decValid = valid_r;
   assign decDrop = drop_r;
   assign lookupVid = vid_r;
   assign outPrio = prio_r;
   assign fwdMask = mask_r;
   assign rxMonitor = mon_r;
   assign learnOk = learn_r;
   assign egressTag = tag_r;
endmodule

/* File: hdl/port_reg_bank.sv */
// Wishbone classic slave holding the control and default tag registers
`timescale 1ns/1ps
module port_reg_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   // Register contents
   port_cfg_if.src cfg
);
   port_vlan_pkg::bus_state_e state_r, state_nxt;
   logic [15:0] ctrl_r, ctrl_nxt, tag_r, tag_nxt, laneMask;
   logic [31:0] datR_r, datR_nxt;
   logic req, hitCtrl, hitTag;

   for (genvar b = 0; b < 2; b++) begin : g_lane
      assign laneMask[8*b +: 8] = {8{wbSel[b]}};
   end

   assign req = wbCyc & wbStb;
   assign hitCtrl = wbAdr[7:2] == port_vlan_pkg::CTRL_IDX;
   assign hitTag = wbAdr[7:2] == port_vlan_pkg::TAG_IDX;

   always_comb begin
      logic [15:0] mc, mt;
      mc = port_vlan_pkg::CTRL_WMASK & laneMask;
      mt = port_vlan_pkg::TAG_WMASK & laneMask;
      state_nxt = (req && state_r == port_vlan_pkg::BUS_IDLE) ?
         port_vlan_pkg::BUS_ACK : port_vlan_pkg::BUS_IDLE;
      ctrl_nxt = ctrl_r;
      tag_nxt = tag_r;
      datR_nxt = datR_r;
      // Write lands on the edge where the master sees ack
      if (req && wbWe && state_r == port_vlan_pkg::BUS_ACK) begin
         if (hitCtrl) begin
            ctrl_nxt = (ctrl_r & ~mc) | (wbDatW[15:0] & mc);
         end
         if (hitTag) begin
            tag_nxt = (tag_r & ~mt) | (wbDatW[15:0] & mt);
         end
      end
      if (req && state_r == port_vlan_pkg::BUS_IDLE) begin
         // Unmapped offsets read zero and ignore writes
         datR_nxt = hitCtrl ? {16'h0000, ctrl_r} :
            hitTag ? {16'h0000, tag_r} : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= port_vlan_pkg::BUS_IDLE;
         ctrl_r <= port_vlan_pkg::CTRL_RST;
         tag_r <= port_vlan_pkg::TAG_RST;
         datR_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         tag_r <= tag_nxt;
         datR_r <= datR_nxt;
      end
   end

   assign wbAck = state_r == port_vlan_pkg::BUS_ACK;
   assign wbDatR = datR_r;
   assign cfg.ctrlReg = ctrl_r;
   assign cfg.tagReg = tag_r;
endmodule

/* File: hdl/port_vlan_forwarding_control.sv */
// Top of the per-port VLAN and forwarding control block
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module port_vlan_forwarding_control (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   // Link state
   input wire logic autoNegotiationResult,
   // Ingress packet descriptor
   input wire logic pktValid,
   input wire logic pktTagged,
   input wire logic [11:0] pktVid,
   input wire logic [2:0] pktPrio,
   input wire logic pktCfi,
   input wire logic [2:0] tableMembers,
   input wire logic [2:0] destMask,
   // Frame boundaries
   input wire logic rxFrameStart,
   input wire logic rxFrameEnd,
   input wire logic txFrameStart,
   input wire logic txFrameEnd,
   // Ingress decision
   output logic decValid,
   output logic decDrop,
   output logic [11:0] lookupVid,
   output logic [2:0] outPrio,
   output logic [2:0] fwdMask,
   output logic rxMonitor,
   output logic learnOk,
   output logic [15:0] egressTag,
   // Port controls
   output logic flowCtrlEn,
   output logic backPressureEn,
   output logic txGate,
   output logic rxGate,
   output logic learnDisable,
   output logic mirrorDest,
   output logic txMonitor
);
   port_cfg_if cfg ();

   port_reg_bank u_bank (
      .clk(clk),
      .reset(reset),
      .wbCyc(wbCyc),
      .wbStb(wbStb),
      .wbWe(wbWe),
      .wbAdr(wbAdr),
      .wbSel(wbSel),
      .wbDatW(wbDatW),
      .wbDatR(wbDatR),
      .wbAck(wbAck),
      .cfg(cfg.src)
   );

   port_ingress_decide u_decide (
      .clk(clk),
      .reset(reset),
      .cfg(cfg.dst),
      .pktValid(pktValid),
      .pktTagged(pktTagged),
      .pktVid(pktVid),
      .pktPrio(pktPrio),
      .pktCfi(pktCfi),
      .tableMembers(tableMembers),
      .destMask(destMask),
      .decValid(decValid),
      .decDrop(decDrop),
      .lookupVid(lookupVid),
      .outPrio(outPrio),
      .fwdMask(fwdMask),
      .rxMonitor(rxMonitor),
      .learnOk(learnOk),
      .egressTag(egressTag)
   );

   logic [15:0] c;
   logic fc_r, fc_nxt, bp_r, bp_nxt, tx_r, tx_nxt, rx_r, rx_nxt;
   logic lrn_r, lrn_nxt, mir_r, mir_nxt, txMon_r, txMon_nxt;
   logic txBusy_r, txBusy_nxt, rxBusy_r, rxBusy_nxt;

   assign c = cfg.ctrlReg;

   always_comb begin
      fc_nxt = c[port_vlan_pkg::FORCE_FC_BIT] | autoNegotiationResult;
      bp_nxt = c[port_vlan_pkg::BACKP_BIT];
      lrn_nxt = c[port_vlan_pkg::LEARN_OFF_BIT];
      mir_nxt = c[port_vlan_pkg::MIRROR_DST_BIT];
      // Gates only move between frames so a frame is never cut short
      tx_nxt = txBusy_r ? tx_r : c[port_vlan_pkg::TX_EN_BIT];
      rx_nxt = rxBusy_r ? rx_r : c[port_vlan_pkg::RX_EN_BIT];
      txBusy_nxt = txBusy_r;
      if (txFrameStart && tx_nxt) begin
         txBusy_nxt = 1'b1;
      end else if (txFrameEnd) begin
         txBusy_nxt = 1'b0;
      end
      rxBusy_nxt = rxBusy_r;
      if (rxFrameStart && rx_nxt) begin
         rxBusy_nxt = 1'b1;
      end else if (rxFrameEnd) begin
         rxBusy_nxt = 1'b0;
      end
      // Only frames actually let out are mirrored
      txMon_nxt = txFrameStart && !txBusy_r && tx_nxt
         && c[port_vlan_pkg::TX_SNIFF_BIT];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fc_r <= 1'b0;
         bp_r <= 1'b0;
         tx_r <= port_vlan_pkg::CTRL_RST[port_vlan_pkg::TX_EN_BIT];
         rx_r <= port_vlan_pkg::CTRL_RST[port_vlan_pkg::RX_EN_BIT];
         lrn_r <= 1'b0;
         mir_r <= 1'b0;
         txMon_r <= 1'b0;
         txBusy_r <= 1'b0;
         rxBusy_r <= 1'b0;
      end else begin
         fc_r <= fc_nxt;
         bp_r <= bp_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         lrn_r <= lrn_nxt;
         mir_r <= mir_nxt;
         txMon_r <= txMon_nxt;
         txBusy_r <= txBusy_nxt;
         rxBusy_r <= rxBusy_nxt;
      end
   end

   assign flowCtrlEn = fc_r;
   assign backPressureEn = bp_r;
   assign txGate = tx_r;
   assign rxGate = rx_r;
   assign learnDisable = lrn_r;
   assign mirrorDest = mir_r;
   assign txMonitor = txMon_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_ack_one_cycle: assert property (
      wbAck |=> !wbAck)
      else $error("ack held more than one cycle");

   chk_ack_after_req: assert property (
      (wbCyc && wbStb && !wbAck) |=> wbAck)
      else $error("request not answered next cycle");

   chk_write_readback: assert property (
      (wbCyc && wbStb && wbWe && wbAck && wbAdr[7:2] == port_vlan_pkg::TAG_IDX
       && wbSel[1:0] == 2'b11)
      |=> cfg.tagReg == $past(wbDatW[15:0]))
      else $error("default tag did not take written value");

   chk_reserved_zero: assert property (
      !c[15] && !c[4])
      else $error("reserved control bit set");

   chk_flow_force: assert property (
      c[port_vlan_pkg::FORCE_FC_BIT] ##1 c[port_vlan_pkg::FORCE_FC_BIT] |-> flowCtrlEn)
      else $error("flow control not forced on");

   chk_backp_follow: assert property (
      ##1 backPressureEn == $past(c[port_vlan_pkg::BACKP_BIT]))
      else $error("back pressure out of step with control");

   chk_tx_hold: assert property (
      (txBusy_r && !txFrameEnd) |=> $stable(txGate))
      else $error("transmit gate moved inside a frame");

   chk_tx_blocked: assert property (
      !txGate |-> !txMonitor)
      else $error("monitored transmit while transmission blocked");

   chk_rx_drop: assert property (
      (pktValid && !c[port_vlan_pkg::RX_EN_BIT]) |=> decValid && decDrop)
      else $error("packet passed with reception disabled");

   chk_filter_drop: assert property (
      (pktValid && c[port_vlan_pkg::FILT_BIT] && !tableMembers[0]) |=> decDrop)
      else $error("non-member packet not filtered");

   chk_vid_mismatch_drop: assert property (
      (pktValid && c[port_vlan_pkg::DEF_VID_ONLY_BIT] && pktTagged
       && pktVid != port_vlan_pkg::NULL_VID && pktVid != cfg.tagReg[11:0]) |=> decDrop)
      else $error("foreign VLAN ID not discarded");

   chk_null_vid: assert property (
      (pktValid && (!pktTagged || pktVid == port_vlan_pkg::NULL_VID))
      |=> lookupVid == $past(cfg.tagReg[11:0]))
      else $error("lookup VID not default for untagged packet");

   chk_prio_ceiling: assert property (
      (pktValid && c[port_vlan_pkg::PRIO_CEIL_BIT]) |=> outPrio <= $past(cfg.tagReg[15:13]))
      else $error("priority above ceiling");

   chk_member_mask: assert property (
      decValid |-> (fwdMask & ~$past(c[2:0])) == 3'h0)
      else $error("forwarded to excluded destination");

   chk_egress_tag: assert property (
      (pktValid && !pktTagged) |=> egressTag == $past(cfg.tagReg))
      else $error("inserted tag not the default tag");

   chk_learn_off: assert property (
      (pktValid && c[port_vlan_pkg::LEARN_OFF_BIT]) |=> !learnOk)
      else $error("learning while disabled");

   chk_mirror_dest: assert property (
      ##1 mirrorDest == $past(c[port_vlan_pkg::MIRROR_DST_BIT]))
      else $error("mirror destination out of step");

   chk_rx_sniff: assert property (
      pktValid |=> rxMonitor == $past(c[port_vlan_pkg::RX_SNIFF_BIT]))
      else $error("receive monitor mark wrong");

   chk_flow_auto: assert property (
      !c[port_vlan_pkg::FORCE_FC_BIT] |=> flowCtrlEn == $past(autoNegotiationResult))
      else $error("flow control not following negotiation");

   chk_learn_out: assert property (
      ##1 learnDisable == $past(c[port_vlan_pkg::LEARN_OFF_BIT]))
      else $error("learning disable out of step");

   chk_tx_idle_follow: assert property (
      !txBusy_r |=> txGate == $past(c[port_vlan_pkg::TX_EN_BIT]))
      else $error("transmit gate not following control between frames");

   chk_rx_idle_follow: assert property (
      !rxBusy_r |=> rxGate == $past(c[port_vlan_pkg::RX_EN_BIT]))
      else $error("receive gate not following control between frames");

   chk_rx_hold: assert property (
      (rxBusy_r && !rxFrameEnd) |=> $stable(rxGate))
      else $error("receive gate moved inside a frame");

   chk_tx_sniff_mark: assert property (
      (txFrameStart && !txBusy_r && c[port_vlan_pkg::TX_EN_BIT]
       && c[port_vlan_pkg::TX_SNIFF_BIT]) |=> txMonitor)
      else $error("transmitted frame not marked monitored");

   chk_tx_sniff_off: assert property (
      !c[port_vlan_pkg::TX_SNIFF_BIT] |=> !txMonitor)
      else $error("transmit monitor mark without sniff");

   chk_tx_mark_pulse: assert property (
      txMonitor |=> !txMonitor)
      else $error("transmit monitor mark longer than one cycle");

   chk_dec_follow: assert property (
      ##1 decValid == $past(pktValid))
      else $error("decision strobe out of step with descriptor");

   chk_dec_hold: assert property (
      !pktValid |=> $stable(decDrop) && $stable(lookupVid) && $stable(outPrio)
       && $stable(fwdMask) && $stable(egressTag))
      else $error("decision changed without a packet");

   chk_drop_clear: assert property (
      (pktValid && c[port_vlan_pkg::RX_EN_BIT] && !c[port_vlan_pkg::FILT_BIT]
       && !c[port_vlan_pkg::DEF_VID_ONLY_BIT]) |=> !decDrop)
      else $error("packet dropped with all filters off");

   chk_lookup_tagged: assert property (
      (pktValid && pktTagged && pktVid != port_vlan_pkg::NULL_VID)
      |=> lookupVid == $past(pktVid))
      else $error("lookup VID not the packet VID");

   chk_prio_pass: assert property (
      (pktValid && pktTagged && !c[port_vlan_pkg::PRIO_CEIL_BIT])
      |=> outPrio == $past(pktPrio))
      else $error("priority changed with ceiling off");

   chk_member_pass: assert property (
      pktValid |=> fwdMask == $past(destMask & c[port_vlan_pkg::MEMBER_HI:0]))
      else $error("membership mask not applied");

   chk_egress_tagged: assert property (
      (pktValid && pktTagged) |=> egressTag[15:12] == $past({pktPrio, pktCfi}))
      else $error("tagged packet lost its own priority or CFI");

   chk_ctrl_write: assert property (
      (wbCyc && wbStb && wbWe && wbAck && wbAdr[7:2] == port_vlan_pkg::CTRL_IDX
       && wbSel[1:0] == 2'b11)
      |=> cfg.ctrlReg == ($past(wbDatW[15:0]) & port_vlan_pkg::CTRL_WMASK))
      else $error("control register did not take written value");

   cov_write_ctrl: cover property (
      wbCyc && wbStb && wbWe && wbAck && wbAdr[7:2] == port_vlan_pkg::CTRL_IDX);
   cov_filter_drop: cover property (decValid && decDrop);
   cov_tx_sniff: cover property (txMonitor);
   cov_ceiling: cover property (decValid && outPrio < $past(pktPrio));
   cov_gate_deferred: cover property (txBusy_r && !c[port_vlan_pkg::TX_EN_BIT] && txGate);
endmodule

/* File: hdl/port_vlan_pkg.sv */
// Constants, register map and field layout of the port forwarding control block
// Function
// - Ingress filter bit 14 drops packets whose table membership excludes this port.
// - Bit 13 discards packets whose VLAN ID differs from the default VLAN ID.
// - Bit 12 forces flow control on; clear follows auto-negotiation result.
// - Bit 11 enables half-duplex back pressure; resets to zero.
// - Bit 10, reset one, allows transmission; clear blocks all transmission; the code keeps txGate open until a transmit frame in progress ends.
// - Bit 9, reset one, allows reception; clear blocks all reception; the code keeps rxGate open until a receive frame in progress ends.
// - Bit 8 set stops source address learning from this port.
// - Bit 7 makes the port the mirror destination for monitored packets.
// - Bit 6 marks every received packet monitored and copies it to mirror.
// - Bit 5 marks every transmitted packet monitored and copies it to mirror; the code leaves a frame starting in the cycle the previous one ends unmarked.
// - Bit 3 caps packet priority at the default tag priority.
// - Membership bits 2:0, reset 0x7: host, port 2, port 1.
// - Forward only to destinations whose membership bit is set.
// - Default tag: priority 15:13, CFI 12, VLAN ID 11:0 reset 0x001.
// - Default tag belongs to untagged ingress packets and is used for egress tagging.
// - Untagged or null-VID packets use the default VLAN ID for lookup.
// - Tag inserted on egress for untagged packets is the ingress default tag.
package port_vlan_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] CTRL_IDX = 6'h02;
   localparam logic [5:0] TAG_IDX = 6'h04;
   localparam logic [15:0] CTRL_RST = 16'h0607;
   localparam logic [15:0] TAG_RST = 16'h0001;
   localparam logic [15:0] CTRL_WMASK = 16'h7fef;
   localparam logic [15:0] TAG_WMASK = 16'hffff;
   // Control fields
   localparam int FILT_BIT = 14;
   localparam int DEF_VID_ONLY_BIT = 13;
   localparam int FORCE_FC_BIT = 12;
   localparam int BACKP_BIT = 11;
   localparam int TX_EN_BIT = 10;
   localparam int RX_EN_BIT = 9;
   localparam int LEARN_OFF_BIT = 8;
   localparam int MIRROR_DST_BIT = 7;
   localparam int RX_SNIFF_BIT = 6;
   localparam int TX_SNIFF_BIT = 5;
   localparam int PRIO_CEIL_BIT = 3;
   localparam int MEMBER_HI = 2;
   // Default tag fields
   localparam int PRIO_HI = 15;
   localparam int PRIO_LO = 13;
   localparam int CFI_BIT = 12;
   localparam int VID_HI = 11;
   // Membership bit of this port itself (port 1)
   localparam int SELF_BIT = 0;
   localparam logic [11:0] NULL_VID = 12'h000;
   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_e;
endpackage

/* File: verification/tb_port_vlan_forwarding_control.sv */
// Self-checking bench for the port VLAN forwarding control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_port_vlan_forwarding_control;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatW = 32'h0, wbDatR;
   logic autoNegotiationResult = 1'b0, pktValid = 1'b0, pktTagged = 1'b0, pktCfi = 1'b0;
   logic [11:0] pktVid = 12'h000, lookupVid;
   logic [2:0] pktPrio = 3'h0, tableMembers = 3'h0, destMask = 3'h0, outPrio, fwdMask;
   logic rxFrameStart = 1'b0, rxFrameEnd = 1'b0, txFrameStart = 1'b0, txFrameEnd = 1'b0;
   logic decValid, decDrop, rxMonitor, learnOk, flowCtrlEn, backPressureEn;
   logic txGate, rxGate, learnDisable, mirrorDest, txMonitor;
   logic [15:0] egressTag;
   logic [15:0] ctrlSh = 16'h0607, tagSh = 16'h0001;
   logic [36:0] decQ[$], monExp;
   logic [31:0] rdQ[$], rdExp;
   logic [36:0] decSeen;
   assign decSeen = {decDrop, lookupVid, outPrio, fwdMask, rxMonitor, learnOk, egressTag};
   int seed = 32'hc907c164;
   int n_fail = 0;
   int compares = 0;

   port_vlan_forwarding_control DUT (.clk, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
      .wbDatW, .wbDatR, .wbAck, .autoNegotiationResult, .pktValid, .pktTagged, .pktVid,
      .pktPrio, .pktCfi, .tableMembers, .destMask, .rxFrameStart, .rxFrameEnd,
      .txFrameStart, .txFrameEnd, .decValid, .decDrop, .lookupVid, .outPrio, .fwdMask,
      .rxMonitor, .learnOk, .egressTag, .flowCtrlEn, .backPressureEn, .txGate, .rxGate,
      .learnDisable, .mirrorDest, .txMonitor);

   always #2.5 clk = ~clk;

   task automatic final_report();
      if (decQ.size() + rdQ.size() != 0) n_fail++;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Expected decision, worked out from the shadow registers
   function automatic logic [36:0] decExp(input logic tg, input logic [11:0] vid,
      input logic [2:0] pr, input logic cf, input logic [2:0] tm, input logic [2:0] dm);
      logic [11:0] lv;
      logic [2:0] op;
      logic dr;
      lv = (!tg || vid == 12'h000) ? tagSh[11:0] : vid;
      op = tg ? pr : tagSh[15:13];
      if (ctrlSh[3] && op > tagSh[15:13]) op = tagSh[15:13];
      dr = !ctrlSh[9] || (ctrlSh[14] && !tm[0]) || (ctrlSh[13] && lv != tagSh[11:0]);
      return {dr, lv, op, dm & ctrlSh[2:0], ctrlSh[6], !ctrlSh[8], tg ? {pr, cf, lv} : tagSh};
   endfunction

   // Classic single cycle: hold until ack is sampled, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
      input logic [15:0] d, input logic [31:0] e);
      logic [15:0] hi;
      hi = 16'($random(seed));
      if (!we) rdQ.push_back(e);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= sel;
      wbDatW <= {hi, d};
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [15:0] d);
      logic [15:0] m;
      m = {{8{sel[1]}}, {8{sel[0]}}};
      if (adr == 8'h08) m = m & port_vlan_pkg::CTRL_WMASK;
      if (adr == 8'h08) ctrlSh = (ctrlSh & ~m) | (d & m);
      if (adr == 8'h10) tagSh = (tagSh & ~m) | (d & m);
      wb(1'b1, adr, sel, d, 32'h0);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [15:0] e);
      wb(1'b0, adr, 4'hf, 16'h0000, {16'h0000, e});
   endtask

   task automatic chkCtl();
      logic [5:0] ex, sn;
      repeat (2) @(posedge clk);
      #1;
      ex = {ctrlSh[12] | autoNegotiationResult, ctrlSh[11:7]};
      sn = {flowCtrlEn, backPressureEn, txGate, rxGate, learnDisable, mirrorDest};
      `CHK("controls", ex, sn)
   endtask

   // One descriptor per call; calls in a row give back-to-back packets
   task automatic pkt();
      logic [31:0] r;
      logic [11:0] vid;
      r = $random(seed);
      vid = (r[2:1] == 2'd0) ? 12'h000 : (r[2:1] == 2'd1) ? tagSh[11:0] : r[31:20];
      decQ.push_back(decExp(r[0], vid, r[5:3], r[6], r[9:7], r[12:10]));
      @(posedge clk);
      pktValid <= 1'b1;
      pktTagged <= r[0];
      pktVid <= vid;
      pktPrio <= r[5:3];
      pktCfi <= r[6];
      tableMembers <= r[9:7];
      destMask <= r[12:10];
   endtask

   task automatic frame(input logic st);
      @(posedge clk);
      txFrameStart <= st;
      rxFrameStart <= st;
      txFrameEnd <= !st;
      rxFrameEnd <= !st;
      @(posedge clk);
      {txFrameStart, rxFrameStart, txFrameEnd, rxFrameEnd} <= 4'h0;
   endtask

   always @(posedge clk) begin
      if (decValid === 1'b1) begin
         monExp = (decQ.size() != 0) ? decQ.pop_front() : 'x;
         `CHK("decision", monExp, decSeen)
      end
      if (wbAck === 1'b1 && wbWe === 1'b0) begin
         rdExp = (rdQ.size() != 0) ? rdQ.pop_front() : 'x;
         `CHK("read data", rdExp, wbDatR)
      end
   end

   initial begin
      #100000;
      n_fail++;
      final_report();
   end

   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      chkCtl();
      rd(8'h08, 16'h0607);
      rd(8'h10, 16'h0001);
      wr(8'h0c, 4'h3, 16'hffff);
      rd(8'h0c, 16'h0000);
      rd(8'h08, 16'h0607);
      wr(8'h10, 4'h1, 16'hffaa);
      rd(8'h10, tagSh);
      // Transmit sniff pulse, then gate change held off until frame end
      wr(8'h08, 4'h3, 16'h0627);
      chkCtl();
      frame(1'b1);
      #1;
      `CHK("txMonitor", 1'b1, txMonitor)
      @(posedge clk);
      #1;
      `CHK("txMonitor", 1'b0, txMonitor)
      wr(8'h08, 4'h3, 16'h0027);
      repeat (3) @(posedge clk);
      #1;
      `CHK("gates in frame", 2'b11, {txGate, rxGate})
      frame(1'b0);
      chkCtl();
      frame(1'b1);
      #1;
      `CHK("txMonitor blocked", 1'b0, txMonitor)
      frame(1'b0);
      repeat (40) begin
         @(posedge clk);
         autoNegotiationResult <= 1'($random(seed));
         wr(8'h08, 4'h3, 16'($random(seed)));
         wr(8'h10, 4'h3, 16'($random(seed)));
         rd(8'h08, ctrlSh);
         rd(8'h10, tagSh);
         chkCtl();
         repeat (6) pkt();
         @(posedge clk);
         pktValid <= 1'b0;
         repeat (3) @(posedge clk);
      end
      final_report();
   end
endmodule
